// file: logic/meter_cfg_pkg.sv
/*
 * Constants for the metering output configuration register bank:
 * register addresses, field positions, reset values and field encodings.
 * Assumes registers are reached at their printed addresses through the
 * device's serial-port register access path, 16-bit data.
 */
package meter_cfg_pkg;
  localparam int          AW = 16;
  localparam int          DW = 16;
  // Register addresses
  localparam logic [15:0] ADDR_GEN_CFG_LOW = 16'h0481;
  localparam logic [15:0] ADDR_PULSE_MODE  = 16'h0490;
  localparam logic [15:0] ADDR_ACCUM_MODE  = 16'h0492;
  localparam logic [15:0] ADDR_PEAK_OC     = 16'h0493;
  localparam logic [15:0] ADDR_ZERO_CROSS_CONFIG      = 16'h049A;
  localparam logic [15:0] ADDR_SIGN_STAT   = 16'h049D;
  // general_config_low fields
  localparam int          B_ZERO_CROSS_OUT_ENABLE  = 2;
  localparam int          B_DR_OUT_OE  = 1;
  localparam int          B_SOFT_RST   = 0;
  // pulse_output_mode fields
  localparam int          B_OUT2_OFF   = 7;
  localparam int          B_OUT1_OFF   = 6;
  localparam int          B_SRC2_LSB   = 3;
  localparam int          B_SRC1_LSB   = 0;
  localparam int          SRC_W        = 3;
  // accumulation_mode fields
  localparam int          B_LINE_FREQ  = 4;
  localparam int          B_VAR_LSB    = 2;
  localparam int          B_WATT_LSB   = 0;
  localparam int          ACC_W        = 2;
  // peak_overcurrent_config fields
  localparam int          B_PEAK_LSB   = 2;
  localparam int          B_OC_B       = 1;
  localparam int          B_OC_A       = 0;
  // zero_cross_config and power_sign_status fields
  localparam int          B_ZX_LPF_OFF = 0;
  localparam int          B_SIGN_P2    = 7;
  localparam int          B_SIGN_P1    = 6;
  localparam int          B_SIGN_VAR_A = 1;
  localparam int          B_SIGN_W_A   = 0;
  // Reset values
  localparam logic [15:0] RST_VAL      = 16'h0000;
  // Energy source encodings
  localparam logic [2:0]  SRC_ACTIVE   = 3'h0;
  localparam logic [2:0]  SRC_APPARENT = 3'h2;
  localparam logic [2:0]  SRC_REACTIVE = 3'h4;
  // Peak detection selection encodings
  typedef enum logic [1:0] {
    PEAK_OFF  = 2'b00,
    PEAK_A    = 2'b01,
    PEAK_B    = 2'b10,
    PEAK_BOTH = 2'b11
  } peak_sel_e;
endpackage

// file: logic/pulse_cfg_if.sv
/*
 * Carries the disable bit and energy source select of one pulse output
 * from the register bank to its pin logic.
 * Assumes both ends run on core_clk.
 */
`timescale 1ns/10ps
interface pulse_cfg_if;
  logic       out_off;
  logic [2:0] src_sel;
  modport ctrl (output out_off, output src_sel);
  modport pin  (input out_off, input src_sel);
endinterface

// file: logic/pulse_pin.sv
/*
 * One frequency output pin: picks an energy pulse train, holds the pin
 * high when disabled, routes an alternate signal when asked, and raises
 * the status flag request for accumulated pulses.
 * Assumes pulse trains are active low and synchronous to core_clk.
 */
`timescale 1ns/10ps
module pulse_pin (
  input  wire logic core_clk,
  input  wire logic srst,
  pulse_cfg_if.pin  cfg,
  input  wire logic active_pulse,
  input  wire logic apparent_pulse,
  input  wire logic reactive_pulse,
  input  wire logic accum_event,
  input  wire logic alt_en,
  input  wire logic alt_val,
  output logic      pin_q,
  output logic      flag_set_q
);
  logic pin_d;

  // Alternate routing first, then disable, then the chosen energy
  always_comb begin
    if (alt_en) begin
      pin_d = alt_val;
    end else if (cfg.out_off) begin
      pin_d = 1'b1;
    end else if (cfg.src_sel == meter_cfg_pkg::SRC_ACTIVE) begin
      pin_d = active_pulse;
    end else if (cfg.src_sel == meter_cfg_pkg::SRC_APPARENT) begin
      pin_d = apparent_pulse;
    end else if (cfg.src_sel == meter_cfg_pkg::SRC_REACTIVE) begin
      pin_d = reactive_pulse;
    end else begin
      pin_d = 1'b1;                                  // Unlisted codes stay idle
    end
  end

  // Pin register; idle level is high
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin_q <= 1'b1;
    end else begin
      pin_q <= pin_d;
    end
  end

  // Status flag request is suppressed while the output is disabled
  always_ff @(posedge core_clk) begin
    if (srst) begin
      flag_set_q <= 1'b0;
    end else begin
      flag_set_q <= accum_event & ~cfg.out_off;
    end
  end

  a_flag_block: assert property (@(posedge core_clk) disable iff (srst)
    cfg.out_off |=> !flag_set_q) else $error("flag set while disabled");
  a_src_active: assert property (@(posedge core_clk) disable iff (srst)
    (!alt_en && !cfg.out_off && cfg.src_sel == meter_cfg_pkg::SRC_ACTIVE)
    |=> pin_q == $past(active_pulse)) else $error("active source not on pin");
endmodule

// file: logic/sign_latch.sv
/*
 * Holds the read-only power sign flags sampled from the metrology path.
 * Assumes sign inputs are synchronous levels, one = negative.
 */
`timescale 1ns/10ps
module sign_latch (
  input  wire logic       core_clk,
  input  wire logic       clr,
  input  wire logic [3:0] sign_in,
  output logic      [3:0] sign_q
);
  // Sample every cycle; a clear forces positive
  always_ff @(posedge core_clk) begin
    if (clr) begin
      sign_q <= 4'h0;
    end else begin
      sign_q <= sign_in;
    end
  end
endmodule

// file: logic/metering_output_config_regs.sv
/*
 * Configuration and status register bank for the metering output logic:
 * pulse pin routing and disables, energy source selects, accumulation
 * modes, line frequency, peak and overcurrent enables, zero-crossing
 * filter bypass, power sign flags and the self-clearing software reset.
 * Assumes a register access front end (the serial port) presents one
 * access per strobe with 16-bit data, and metrology inputs are synchronous.
 */
// Function
// - Zero-cross enable routes the zero-crossing signal onto pulse pin two.
// - Data-ready enable routes the data-ready signal onto pulse pin two while zero-cross enable is clear.
// - Writing one to soft reset starts a reset; bit clears itself.
// - Pulse output two disable stops pulses and holds pin two high while neither routing enable is set.
// - A disabled output never raises its pulse status flag.
// - Pulse output one disable acts like output two disable on pin one.
// - Source two selects active, apparent or reactive energy for pin two.
// - Source one selects energy for pin one with the same codes.
// - Line frequency select: zero is 50 Hz, one is 60 Hz.
// - Reactive accumulation mode: signed, absolute, positive or negative only.
// - Active accumulation mode uses the same four-mode encoding.
// - Peak select: off, phase A only, channel B only, or both.
// - Overcurrent detection on channel B only while its enable is set.
// - Overcurrent detection on channel A only while its enable is set.
// - Zero-cross filter off bypasses the zero-crossing low-pass filter.
// - Pulse path two sign reads one when its energy is negative.
// - Pulse path one sign reads one when its energy is negative.
// - Reactive sign A reads one when phase A reactive power is negative.
// - Active sign A reads one when phase A active power is negative.
`timescale 1ns/10ps
module metering_output_config_regs (
  input  wire logic        core_clk,
  input  wire logic        srst,
  // Register access port
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic             reg_rd_valid,
  // Energy pulse trains from the frequency converters (active low), accumulation events (active high) and pin two alternate signals
  input  wire logic [1:0]  active_pulse,
  input  wire logic [1:0]  apparent_pulse,
  input  wire logic [1:0]  reactive_pulse,
  input  wire logic [1:0]  pulse_accum_event,
  input  wire logic        zero_cross_signal,
  input  wire logic        data_ready_signal,
  // Sign levels from metrology, one means negative
  input  wire logic        path2_negative,
  input  wire logic        path1_negative,
  input  wire logic        reactive_a_negative,
  input  wire logic        active_a_negative,
  // Pins and controls
  output logic             pulse_out1_pin,
  output logic             pulse_out2_pin,
  output logic [1:0]       pulse_flag_set,
  output logic             soft_reset_out,
  output logic             line_freq_60,
  output logic [1:0]       reactive_accum_mode,
  output logic [1:0]       active_accum_mode,
  output logic             peak_a_enable,
  output logic             peak_b_enable,
  output logic             overcurrent_a_enable,
  output logic             overcurrent_b_enable,
  output logic             zero_cross_filter_off
);
  logic        zx_oe_q;
  logic        dr_oe_q;
  logic        out1_off_q;
  logic        out2_off_q;
  logic [2:0]  src1_q;
  logic [2:0]  src2_q;
  logic        freq_q;
  logic [1:0]  var_acc_q;
  logic [1:0]  watt_acc_q;
  logic [1:0]  peak_q;
  logic        oc_a_q;
  logic        oc_b_q;
  logic        zx_lpf_off_q;
  logic        soft_rst_q;
  logic        clr_all;
  logic [3:0]  sign_q;
  logic [15:0] rdata_d;
  logic        alt2_en;
  logic        alt2_val;
  logic        wr_gen;
  logic        wr_mode;
  logic        wr_acc;
  logic        wr_peak;
  logic        wr_zx;

  pulse_cfg_if cfg1 ();
  pulse_cfg_if cfg2 ();

  // Address decode for writes
  assign wr_gen  = reg_wr && (reg_addr == meter_cfg_pkg::ADDR_GEN_CFG_LOW);
  assign wr_mode = reg_wr && (reg_addr == meter_cfg_pkg::ADDR_PULSE_MODE);
  assign wr_acc  = reg_wr && (reg_addr == meter_cfg_pkg::ADDR_ACCUM_MODE);
  assign wr_peak = reg_wr && (reg_addr == meter_cfg_pkg::ADDR_PEAK_OC);
  assign wr_zx   = reg_wr && (reg_addr == meter_cfg_pkg::ADDR_ZERO_CROSS_CONFIG);

  // Hardware reset and software reset clear the same field, pin and sign state
  assign clr_all = srst | soft_rst_q;

  // Soft reset request: one-cycle pulse, never stored as a readable bit
  always_ff @(posedge core_clk) begin
    if (srst) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_gen & reg_wdata[meter_cfg_pkg::B_SOFT_RST] & ~soft_rst_q;
    end
  end

  // Pin two routing enables; only the documented bits are kept
  always_ff @(posedge core_clk) begin
    if (clr_all) begin
      zx_oe_q <= meter_cfg_pkg::RST_VAL[meter_cfg_pkg::B_ZERO_CROSS_OUT_ENABLE];
      dr_oe_q <= meter_cfg_pkg::RST_VAL[meter_cfg_pkg::B_DR_OUT_OE];
    end else if (wr_gen) begin
      zx_oe_q <= reg_wdata[meter_cfg_pkg::B_ZERO_CROSS_OUT_ENABLE];
      dr_oe_q <= reg_wdata[meter_cfg_pkg::B_DR_OUT_OE];
    end
  end

  // Pulse output disables and energy source selects
  always_ff @(posedge core_clk) begin
    if (clr_all) begin
      out1_off_q <= meter_cfg_pkg::RST_VAL[meter_cfg_pkg::B_OUT1_OFF];
      out2_off_q <= meter_cfg_pkg::RST_VAL[meter_cfg_pkg::B_OUT2_OFF];
      src1_q     <= meter_cfg_pkg::RST_VAL[2:0];
      src2_q     <= meter_cfg_pkg::RST_VAL[2:0];
    end else if (wr_mode) begin
      out1_off_q <= reg_wdata[meter_cfg_pkg::B_OUT1_OFF];
      out2_off_q <= reg_wdata[meter_cfg_pkg::B_OUT2_OFF];
      src1_q     <= reg_wdata[meter_cfg_pkg::B_SRC1_LSB +: meter_cfg_pkg::SRC_W];
      src2_q     <= reg_wdata[meter_cfg_pkg::B_SRC2_LSB +: meter_cfg_pkg::SRC_W];
    end
  end

  // Line frequency and accumulation modes
  always_ff @(posedge core_clk) begin
    if (clr_all) begin
      freq_q     <= meter_cfg_pkg::RST_VAL[meter_cfg_pkg::B_LINE_FREQ];
      var_acc_q  <= meter_cfg_pkg::RST_VAL[1:0];
      watt_acc_q <= meter_cfg_pkg::RST_VAL[1:0];
    end else if (wr_acc) begin
      freq_q     <= reg_wdata[meter_cfg_pkg::B_LINE_FREQ];
      var_acc_q  <= reg_wdata[meter_cfg_pkg::B_VAR_LSB +: meter_cfg_pkg::ACC_W];
      watt_acc_q <= reg_wdata[meter_cfg_pkg::B_WATT_LSB +: meter_cfg_pkg::ACC_W];
    end
  end

  // Peak selection and overcurrent enables
  always_ff @(posedge core_clk) begin
    if (clr_all) begin
      peak_q <= meter_cfg_pkg::RST_VAL[1:0];
      oc_a_q <= meter_cfg_pkg::RST_VAL[meter_cfg_pkg::B_OC_A];
      oc_b_q <= meter_cfg_pkg::RST_VAL[meter_cfg_pkg::B_OC_B];
    end else if (wr_peak) begin
      peak_q <= reg_wdata[meter_cfg_pkg::B_PEAK_LSB +: 2];
      oc_a_q <= reg_wdata[meter_cfg_pkg::B_OC_A];
      oc_b_q <= reg_wdata[meter_cfg_pkg::B_OC_B];
    end
  end

  // Zero-crossing filter bypass
  always_ff @(posedge core_clk) begin
    if (clr_all) begin
      zx_lpf_off_q <= meter_cfg_pkg::RST_VAL[meter_cfg_pkg::B_ZX_LPF_OFF];
    end else if (wr_zx) begin
      zx_lpf_off_q <= reg_wdata[meter_cfg_pkg::B_ZX_LPF_OFF];
    end
  end

  // Control outputs straight from the field registers
  assign line_freq_60          = freq_q;
  assign reactive_accum_mode   = var_acc_q;
  assign active_accum_mode     = watt_acc_q;
  assign overcurrent_a_enable  = oc_a_q;
  assign overcurrent_b_enable  = oc_b_q;
  assign zero_cross_filter_off = zx_lpf_off_q;
  assign soft_reset_out        = soft_rst_q;

  // Peak enables decoded from the selection code
  always_comb begin
    case (meter_cfg_pkg::peak_sel_e'(peak_q))
      meter_cfg_pkg::PEAK_A: begin
        peak_a_enable = 1'b1;
        peak_b_enable = 1'b0;
      end
      meter_cfg_pkg::PEAK_B: begin
        peak_a_enable = 1'b0;
        peak_b_enable = 1'b1;
      end
      meter_cfg_pkg::PEAK_BOTH: begin
        peak_a_enable = 1'b1;
        peak_b_enable = 1'b1;
      end
      default: begin
        peak_a_enable = 1'b0;
        peak_b_enable = 1'b0;
      end
    endcase
  end

  // Pin two alternate function; zero-crossing has priority
  always_comb begin
    alt2_en  = zx_oe_q | dr_oe_q;
    alt2_val = zx_oe_q ? zero_cross_signal : data_ready_signal;
  end

  assign cfg1.out_off = out1_off_q;
  assign cfg1.src_sel = src1_q;
  assign cfg2.out_off = out2_off_q;
  assign cfg2.src_sel = src2_q;

  pulse_pin u_pin1 (
    .core_clk       (core_clk),
    .srst           (clr_all),
    .cfg            (cfg1),
    .active_pulse   (active_pulse[0]),
    .apparent_pulse (apparent_pulse[0]),
    .reactive_pulse (reactive_pulse[0]),
    .accum_event    (pulse_accum_event[0]),
    .alt_en         (1'b0),
    .alt_val        (1'b1),
    .pin_q          (pulse_out1_pin),
    .flag_set_q     (pulse_flag_set[0])
  );

  pulse_pin u_pin2 (
    .core_clk       (core_clk),
    .srst           (clr_all),
    .cfg            (cfg2),
    .active_pulse   (active_pulse[1]),
    .apparent_pulse (apparent_pulse[1]),
    .reactive_pulse (reactive_pulse[1]),
    .accum_event    (pulse_accum_event[1]),
    .alt_en         (alt2_en),
    .alt_val        (alt2_val),
    .pin_q          (pulse_out2_pin),
    .flag_set_q     (pulse_flag_set[1])
  );

  sign_latch u_sign (
    .core_clk (core_clk),
    .clr      (clr_all),
    .sign_in  ({path2_negative, path1_negative, reactive_a_negative, active_a_negative}),
    .sign_q   (sign_q)
  );

  // Read mux; unmapped addresses and reserved bits read zero
  always_comb begin
    rdata_d = 16'h0000;
    if (reg_addr == meter_cfg_pkg::ADDR_GEN_CFG_LOW) begin
      rdata_d[meter_cfg_pkg::B_ZERO_CROSS_OUT_ENABLE] = zx_oe_q;         // Soft reset reads zero
      rdata_d[meter_cfg_pkg::B_DR_OUT_OE] = dr_oe_q;
    end else if (reg_addr == meter_cfg_pkg::ADDR_PULSE_MODE) begin
      rdata_d[meter_cfg_pkg::B_OUT2_OFF] = out2_off_q;
      rdata_d[meter_cfg_pkg::B_OUT1_OFF] = out1_off_q;
      rdata_d[meter_cfg_pkg::B_SRC2_LSB +: meter_cfg_pkg::SRC_W] = src2_q;
      rdata_d[meter_cfg_pkg::B_SRC1_LSB +: meter_cfg_pkg::SRC_W] = src1_q;
    end else if (reg_addr == meter_cfg_pkg::ADDR_ACCUM_MODE) begin
      rdata_d[meter_cfg_pkg::B_LINE_FREQ] = freq_q;
      rdata_d[meter_cfg_pkg::B_VAR_LSB +: meter_cfg_pkg::ACC_W]  = var_acc_q;
      rdata_d[meter_cfg_pkg::B_WATT_LSB +: meter_cfg_pkg::ACC_W] = watt_acc_q;
    end else if (reg_addr == meter_cfg_pkg::ADDR_PEAK_OC) begin
      rdata_d[meter_cfg_pkg::B_PEAK_LSB +: 2] = peak_q;
      rdata_d[meter_cfg_pkg::B_OC_B] = oc_b_q;
      rdata_d[meter_cfg_pkg::B_OC_A] = oc_a_q;
    end else if (reg_addr == meter_cfg_pkg::ADDR_ZERO_CROSS_CONFIG) begin
      rdata_d[meter_cfg_pkg::B_ZX_LPF_OFF] = zx_lpf_off_q;
    end else if (reg_addr == meter_cfg_pkg::ADDR_SIGN_STAT) begin
      rdata_d[meter_cfg_pkg::B_SIGN_P2]    = sign_q[3];
      rdata_d[meter_cfg_pkg::B_SIGN_P1]    = sign_q[2];
      rdata_d[meter_cfg_pkg::B_SIGN_VAR_A] = sign_q[1];
      rdata_d[meter_cfg_pkg::B_SIGN_W_A]   = sign_q[0];
    end
  end

  // Read data is held until the next read, so a slow front end can take it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata    <= 16'h0000;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_d;
      end
    end
  end

  sequence s_soft_reset_request_write;
    wr_gen && reg_wdata[meter_cfg_pkg::B_SOFT_RST] && !soft_rst_q;
  endsequence
  sequence s_soft_reset_request_done;
    soft_reset_out ##1 (!soft_reset_out && !zx_oe_q && !out2_off_q && peak_q == 2'b00);
  endsequence

  a_soft_reset_request_pulse: assert property (@(posedge core_clk) disable iff (srst)
    s_soft_reset_request_write |=> s_soft_reset_request_done) else $error("soft reset did not clear");
  a_zx_route: assert property (@(posedge core_clk) disable iff (srst)
    (zx_oe_q && !soft_rst_q) |=> pulse_out2_pin == $past(zero_cross_signal))
    else $error("zero crossing not on pin two");
  a_data_ready_signal_route: assert property (@(posedge core_clk) disable iff (srst)
    (!zx_oe_q && dr_oe_q && !soft_rst_q) |=> pulse_out2_pin == $past(data_ready_signal))
    else $error("data ready not on pin two");
  a_pin2_high: assert property (@(posedge core_clk) disable iff (srst)
    (out2_off_q && !alt2_en) |=> pulse_out2_pin) else $error("pin two not high");
  a_pin1_high: assert property (@(posedge core_clk) disable iff (srst)
    out1_off_q |=> pulse_out1_pin) else $error("pin one not high");
  a_rsvd_zero: assert property (@(posedge core_clk) disable iff (srst)
    (reg_rd && reg_addr == meter_cfg_pkg::ADDR_ZERO_CROSS_CONFIG) |=> reg_rdata[15:1] == 15'h0000)
    else $error("reserved bits not zero");
  // A sign sampled in a clear cycle reads zero, so reads right after one are left out
  a_sign_read: assert property (@(posedge core_clk) disable iff (srst)
    (reg_rd && reg_addr == meter_cfg_pkg::ADDR_SIGN_STAT && !soft_rst_q && !$past(clr_all))
    |=> reg_rd_valid && reg_rdata[meter_cfg_pkg::B_SIGN_P2] == $past(path2_negative, 2))
    else $error("sign flag mismatch");
  a_peak_decode: assert property (@(posedge core_clk) disable iff (srst)
    (wr_peak && !soft_rst_q)
    |=> peak_a_enable == $past(reg_wdata[meter_cfg_pkg::B_PEAK_LSB])
        && peak_b_enable == $past(reg_wdata[meter_cfg_pkg::B_PEAK_LSB + 1]))
    else $error("peak select not applied");
  a_oc_enable: assert property (@(posedge core_clk) disable iff (srst)
    (wr_peak && !soft_rst_q)
    |=> (overcurrent_a_enable == $past(reg_wdata[meter_cfg_pkg::B_OC_A]))
        ##1 ($stable(oc_a_q) || $past(wr_peak)))
    else $error("overcurrent enable not applied");
endmodule

// file: test/tb.sv
/*
 * Self-checking bench for the metering output configuration register bank.
 * Assumes the bank answers reads one cycle after the strobe and drives its
 * pins one cycle after the inputs that they follow.
 */
`timescale 1ns/10ps
module tb;
  localparam logic [15:0] A_GEN = meter_cfg_pkg::ADDR_GEN_CFG_LOW;
  localparam logic [15:0] A_PM  = meter_cfg_pkg::ADDR_PULSE_MODE;
  localparam logic [15:0] A_AM  = meter_cfg_pkg::ADDR_ACCUM_MODE;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic        reg_rd_valid;
  logic [1:0]  act = 2'h3;
  logic [1:0]  app = 2'h3;
  logic [1:0]  rea = 2'h3;
  logic [1:0]  evt = 2'h0;
  logic        zx = 1'b0;
  logic        dr = 1'b0;
  logic [3:0]  sgn = 4'h0;
  logic        pin1, pin2, srst_out, lf60, pa, pb, oca, ocb, zxf;
  logic [1:0]  flag, vmode, wmode;
  int          n_errors = 0;
  int          total_checks = 0;
  // Address list ends with an unmapped place; masks give the writable bits
  logic [15:0] addrs [6] = '{A_GEN, A_PM, A_AM, meter_cfg_pkg::ADDR_PEAK_OC,
                             meter_cfg_pkg::ADDR_ZERO_CROSS_CONFIG, 16'h0400};
  logic [15:0] masks [6] = '{16'h0006, 16'h00FF, 16'h001F, 16'h000F, 16'h0001, 16'h0000};

  always #10 core_clk = ~core_clk;

  metering_output_config_regs metering_output_config_regs_inst (
    .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .active_pulse(act), .apparent_pulse(app), .reactive_pulse(rea),
    .pulse_accum_event(evt), .zero_cross_signal(zx), .data_ready_signal(dr),
    .path2_negative(sgn[3]), .path1_negative(sgn[2]), .reactive_a_negative(sgn[1]),
    .active_a_negative(sgn[0]), .pulse_out1_pin(pin1), .pulse_out2_pin(pin2),
    .pulse_flag_set(flag), .soft_reset_out(srst_out), .line_freq_60(lf60),
    .reactive_accum_mode(vmode), .active_accum_mode(wmode), .peak_a_enable(pa),
    .peak_b_enable(pb), .overcurrent_a_enable(oca), .overcurrent_b_enable(ocb),
    .zero_cross_filter_off(zxf));

  task automatic stop_test();
    if (n_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Strobes last exactly one cycle, launched and dropped on falling edges
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    chk(16'(reg_rd_valid), 16'h0001);
    chk(reg_rdata, e);
    // Valid lasts one cycle while the data stands until the next read
    @(negedge core_clk);
    chk(16'(reg_rd_valid), 16'h0000);
    chk(reg_rdata, e);
  endtask

  task automatic t_fields();
    chk(16'({pin2, pin1, flag, srst_out, reg_rd_valid}), 16'h0030);
    for (int i = 0; i < 6; i++) rd(addrs[i], 16'h0000);
    rd(meter_cfg_pkg::ADDR_SIGN_STAT, 16'h0000);
    for (int i = 1; i < 6; i++) wr(addrs[i], 16'hFFFF);
    wr(meter_cfg_pkg::ADDR_SIGN_STAT, 16'hFFFF);
    for (int i = 1; i < 6; i++) rd(addrs[i], masks[i]);
    rd(meter_cfg_pkg::ADDR_SIGN_STAT, 16'h0000);
    chk(16'({lf60, vmode, wmode, pb, pa, ocb, oca, zxf}), 16'h03FF);
    wr(A_AM, 16'h0009);
    chk(16'({lf60, vmode, wmode}), 16'h0009);
    for (int c = 0; c < 4; c++) begin
      wr(meter_cfg_pkg::ADDR_PEAK_OC, 16'(c << 2) | 16'h0001);
      chk(16'({pb, pa, ocb, oca}), 16'((c << 2) | 1));
    end
    wr(meter_cfg_pkg::ADDR_PEAK_OC, 16'h0002);
    wr(meter_cfg_pkg::ADDR_ZERO_CROSS_CONFIG, 16'h0000);
    chk(16'({ocb, oca, zxf}), 16'h0004);
  endtask

  task automatic t_signs();
    sgn = 4'hA;
    rd(meter_cfg_pkg::ADDR_SIGN_STAT, 16'h0082);
    sgn = 4'h5;
    rd(meter_cfg_pkg::ADDR_SIGN_STAT, 16'h0041);
    sgn = 4'h0;
  endtask

  // Only one energy train is low at a time, so the pin shows which was chosen
  task automatic t_source();
    logic hit;
    for (int c = 0; c < 8; c++) begin
      wr(A_PM, 16'((c << 3) | c));
      for (int t = 0; t < 3; t++) begin
        act = (t == 0) ? 2'h0 : 2'h3;
        app = (t == 1) ? 2'h0 : 2'h3;
        rea = (t == 2) ? 2'h0 : 2'h3;
        hit = (c == 0 && t == 0) || (c == 2 && t == 1) || (c == 4 && t == 2);
        @(negedge core_clk);
        chk(16'({pin2, pin1}), hit ? 16'h0000 : 16'h0003);
      end
    end
    app = 2'h3;
    rea = 2'h3;
  endtask

  task automatic t_disable();
    for (int i = 0; i < 4; i++) begin
      wr(A_PM, 16'(i << 6));
      act = 2'h0;
      evt = 2'h3;
      @(negedge core_clk);
      evt = 2'h0;
      chk(16'({pin2, pin1}), 16'(i));
      chk(16'(flag), 16'(~i & 3));
      // Flag request is a one-cycle pulse
      @(negedge core_clk);
      chk(16'(flag), 16'h0000);
    end
  endtask

  // Energy path holds pin two low, so any high level comes from routing
  task automatic t_route();
    wr(A_PM, 16'h0000);
    act = 2'h0;
    for (int c = 1; c < 4; c++) begin
      wr(A_GEN, 16'(c << 1));
      for (int z = 0; z < 2; z++) begin
        zx = z[0];
        dr = ~z[0];
        @(negedge core_clk);
        chk(16'({pin2, pin1}), c[1] ? 16'({zx, 1'b0}) : 16'({dr, 1'b0}));
      end
    end
  endtask

  task automatic t_soft_reset_request();
    wr(A_AM, 16'h0010);
    wr(A_GEN, 16'h0007);
    // Pin one follows the low active train until the clear cycle parks it high
    chk(16'({srst_out, lf60, pin1}), 16'h0006);
    @(negedge core_clk);
    chk(16'({srst_out, lf60, pin1}), 16'h0001);
    rd(A_GEN, 16'h0000);
    rd(A_AM, 16'h0000);
  endtask

  // Watchdog: a run that overstays counts as a mismatch
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    stop_test();
  end

  initial begin
    repeat (16) @(negedge core_clk);
    srst = 1'b0;
    t_fields();
    t_signs();
    t_source();
    t_disable();
    t_route();
    t_soft_reset_request();
    stop_test();
  end
endmodule
